// ==== wrfc_top.sv ====
`timescale 1ns/100ps
`include "wrfc_consts.svh"

// Notes on behaviour
// R1: The time-out flag reads 1 after a time-out, writing 1 clears it.
// R2: With the run bit at 0 the counter is stopped and reloaded.
// R3: With the run bit at 1 counting starts only after a frequency change.
// R4: A time-out loads recovery, locks the mode and resets the system when reset is enabled.
// R5: While locked, writes that would change the frequency are ignored.
// R6: Clearing the run bit unlocks and frequency changes are taken again.
// R7: The CPU and chipset skew fields map to -450 ps up to +600 ps.
// R8: The graphics skew field maps to none, -150, +150 or +300 ps.
// R9: The source select picks the strap select at 0 or N and M at 1.
// R10: On time-out the CPU output moves to the selected recovery value.
// R11: With source select at 1 the N and M values set the recovery rate.
// R12: The ratio comes from the strap at override 0, else from software.
// R13: The time-out counts in 150 ms or 2.5 s prescaler units.
// R14: At zero the flag is set; reset is issued only when enabled.
// R15: Skew and recovery fields survive a watchdog reset, not power-on.

module wrfc_top #(
   parameter int unsigned UNIT_SHORT_CYC = `WRFC_UNIT_SHORT_CYC,
   parameter int unsigned UNIT_LONG_CYC = `WRFC_UNIT_LONG_CYC
) (
   // Reference clock and power-on reset.
   input wire logic clk,
   input wire logic rst_n,
   // Control byte link from the serial engine.
   input wire logic smb_clk,
   input wire logic smb_wr_stb,
   input wire logic smb_rd_stb,
   input wire logic [7:0] smb_addr,
   input wire logic [7:0] smb_wdata,
   output logic smb_busy,
   output logic [7:0] smb_rdata,
   output logic smb_rdata_vld,
   // Strap pins sampled after power-on.
   input wire logic [4:0] strap_frequency_select,
   // Settings and events from the neighbouring control bytes.
   input wire logic [4:0] timeout_count,
   input wire logic timeout_prescale_select,
   input wire logic freq_change,
   input wire logic ratio_source_override,
   input wire logic [4:0] ratio_select_sw,
   // Results toward the synthesiser and the system.
   output logic sys_reset,
   output logic recovery_load,
   output logic recovery_lock,
   output wrfc_pkg::wrfc_recov_t recovery,
   output wrfc_pkg::wrfc_skew_t skew,
   output logic [4:0] ratio_select
);

   // ----------------------------------------------------------------
   // Skew decoding
   // ----------------------------------------------------------------

   // Maps a three bit skew code to signed 150 ps steps.
   function automatic logic signed [3:0] skew3(input logic [2:0] c);
      logic signed [3:0] s;
      s = 4'sh0;
      unique case (c)
         3'h0: s = 4'sh0;
         3'h1: s = -4'sh1;
         3'h2: s = -4'sh2;
         3'h3: s = -4'sh3;
         3'h4: s = 4'sh1;
         3'h5: s = 4'sh2;
         3'h6: s = 4'sh3;
         3'h7: s = 4'sh4;
      endcase
      return s;
   endfunction

   // Maps the two bit graphics skew code to signed 150 ps steps.
   function automatic logic signed [3:0] skew2(input logic [1:0] c);
      logic signed [3:0] s;
      s = 4'sh0;
      unique case (c)
         2'h0: s = 4'sh0;
         2'h1: s = -4'sh1;
         2'h2: s = 4'sh1;
         2'h3: s = 4'sh2;
      endcase
      return s;
   endfunction

   // Number of prescaler units to load; a count of k gives k plus one.
   function automatic logic [5:0] unit_total(input logic [4:0] k);
      return {1'b0, k} + 6'h01;
   endfunction

   wrfc_pkg::wrfc_core_t c_q;
   wrfc_pkg::wrfc_core_t c_d;
   wrfc_pkg::wrfc_link_t l_q;
   wrfc_pkg::wrfc_link_t l_d;

   // ----------------------------------------------------------------
   // Link domain
   // ----------------------------------------------------------------

   // Holds one request at a time and returns read data by handshake.
   always_comb begin
      l_d = l_q;
      l_d.rst_sync = {l_q.rst_sync[0], rst_n};
      l_d.ack_sync = {l_q.ack_sync[0], c_q.ack_tgl};
      l_d.rvld = 1'b0;
      if (!l_q.rst_sync[1]) begin
         // Link reset drops any outstanding request.
         l_d.req_tgl = 1'b0;
         l_d.wr = 1'b0;
         l_d.addr = `WRFC_RST_BYTE;
         l_d.wdata = `WRFC_RST_BYTE;
         l_d.ack_sync = 2'h0;
         l_d.pending = 1'b0;
         l_d.rdata = `WRFC_RST_BYTE;
      end else if (l_q.pending) begin
         // The core has answered once its toggle matches ours.
         if (l_q.ack_sync[1] == l_q.req_tgl) begin
            l_d.pending = 1'b0;
            if (!l_q.wr) begin
               l_d.rdata = c_q.rdata_hold;
               l_d.rvld = 1'b1;
            end
         end
      end else if (smb_wr_stb || smb_rd_stb) begin
         // A strobe is taken only while nothing is outstanding.
         l_d.wr = smb_wr_stb;
         l_d.addr = smb_addr;
         l_d.wdata = smb_wdata;
         l_d.req_tgl = ~l_q.req_tgl;
         l_d.pending = 1'b1;
      end
   end

   // Registers the link domain state.
   always_ff @(posedge smb_clk) begin
      l_q <= l_d;
   end

   // ----------------------------------------------------------------
   // Core domain
   // ----------------------------------------------------------------

   logic new_req;
   logic do_wr;
   logic flag_clr;
   logic expire;
   logic [25:0] unit_last;

   // Decodes the synchronised request and the prescaler limit.
   always_comb begin
      new_req = c_q.req_sync[1] ^ c_q.req_sync[2];
      do_wr = new_req && l_q.wr;
      flag_clr = do_wr && (l_q.addr == `WRFC_OFS_WDOG)
         && l_q.wdata[`WRFC_BIT_FLAG]; // R1
      if (timeout_prescale_select) begin
         unit_last = 26'(UNIT_LONG_CYC - 1); // R13
      end else begin
         unit_last = 26'(UNIT_SHORT_CYC - 1); // R13
      end
      // A restart or a stop in the last cycle wins over the time-out.
      expire = (c_q.wd == wrfc_pkg::WD_COUNT) && c_q.run && !freq_change
         && (c_q.pre_cnt == unit_last) && (c_q.units == 6'h01); // R14
   end

   // Computes the next core state.
   always_comb begin
      c_d = c_q;
      // Synchronisers shift and pulses drop back by default.
      c_d.req_sync = {c_q.req_sync[1], c_q.req_sync[0], l_q.req_tgl};
      c_d.strap_s1 = strap_frequency_select;
      c_d.strap_s2 = c_q.strap_s1;
      c_d.rec_load = 1'b0;

      // Latches the strap select a few cycles after power-on.
      if (c_q.strap_age != `WRFC_STRAP_AGE) begin
         c_d.strap_age = c_q.strap_age + 2'h1;
      end
      if (c_q.strap_age == `WRFC_STRAP_AGE - 2'h1) begin
         c_d.strap_lat = c_q.strap_s2;
      end

      // Serves a register access and answers it.
      if (new_req) begin
         c_d.ack_tgl = c_q.req_sync[1];
         unique case (l_q.addr)
            `WRFC_OFS_WDOG: c_d.rdata_hold = {3'h0, c_q.rst_en, 1'b0,
               c_q.flag, c_q.run, 1'b0};
            `WRFC_OFS_SKEW: c_d.rdata_hold = c_q.skew_byte;
            `WRFC_OFS_RECN: c_d.rdata_hold = c_q.n_byte;
            `WRFC_OFS_RECM: c_d.rdata_hold = c_q.m_byte;
            default: c_d.rdata_hold = `WRFC_RST_BYTE;
         endcase
      end
      // Applies a write; locked mode freezes the recovery bytes.
      if (do_wr) begin
         unique case (l_q.addr)
            `WRFC_OFS_WDOG: begin
               c_d.run = l_q.wdata[`WRFC_BIT_RUN];
               c_d.rst_en = l_q.wdata[`WRFC_BIT_RSTEN];
            end
            `WRFC_OFS_SKEW: c_d.skew_byte = l_q.wdata;
            `WRFC_OFS_RECN: begin
               if (!c_q.lock) begin
                  c_d.n_byte = l_q.wdata; // R5
               end
            end
            `WRFC_OFS_RECM: begin
               if (!c_q.lock) begin
                  c_d.m_byte = l_q.wdata; // R5
               end
            end
            default: c_d.run = c_q.run;
         endcase
      end

      // The time-out event wins over a clear in the same cycle.
      c_d.flag = expire || (c_q.flag && !flag_clr); // R1 R14

      // Watchdog sequencing.
      unique case (c_q.wd)
         wrfc_pkg::WD_STOP: begin
            c_d.pre_cnt = 26'h0; // R2
            c_d.units = unit_total(timeout_count); // R2
            if (c_q.run) begin
               c_d.wd = wrfc_pkg::WD_ARMED;
            end
         end
         wrfc_pkg::WD_ARMED: begin
            c_d.pre_cnt = 26'h0;
            c_d.units = unit_total(timeout_count);
            if (!c_q.run) begin
               c_d.wd = wrfc_pkg::WD_STOP; // R2
            end else if (freq_change) begin
               c_d.wd = wrfc_pkg::WD_COUNT; // R3
            end
         end
         wrfc_pkg::WD_COUNT: begin
            if (!c_q.run) begin
               c_d.wd = wrfc_pkg::WD_STOP; // R2
            end else if (freq_change) begin
               c_d.pre_cnt = 26'h0; // R3
               c_d.units = unit_total(timeout_count);
            end else if (expire) begin
               // Captures recovery, locks and, when rst_en is set, starts the reset pulse.
               c_d.wd = wrfc_pkg::WD_LOCKED; // R4
               c_d.lock = 1'b1; // R4
               c_d.rec_load = 1'b1; // R10
               c_d.rec.use_dividers = c_q.m_byte[`WRFC_BIT_RSEL]; // R9
               c_d.rec.n = c_q.n_byte; // R11
               c_d.rec.m = c_q.m_byte[6:0]; // R11
               c_d.rec.strap = c_q.strap_lat; // R9
               if (c_q.rst_en) begin
                  c_d.rst_cnt = `WRFC_RST_PULSE_CYC; // R14
               end
            end else if (c_q.pre_cnt == unit_last) begin
               c_d.pre_cnt = 26'h0; // R13
               c_d.units = c_q.units - 6'h01;
            end else begin
               c_d.pre_cnt = c_q.pre_cnt + 26'h1;
            end
         end
         wrfc_pkg::WD_LOCKED: begin
            // Only a cleared run bit leaves the locked mode.
            if (!c_q.run) begin
               c_d.wd = wrfc_pkg::WD_STOP; // R6
               c_d.lock = 1'b0; // R6
            end
         end
      endcase

      // Stretches the system reset over a fixed number of cycles.
      if (c_q.rst_cnt != 8'h00 && !(expire && c_q.rst_en)) begin
         c_d.rst_cnt = c_q.rst_cnt - 8'h01;
      end
      c_d.sys_rst = (c_d.rst_cnt != 8'h00); // R4

      // Decodes skews and the ratio source.
      c_d.skew.cpu = skew3(c_q.skew_byte[`WRFC_CPU_HI:`WRFC_CPU_LO]); // R7
      c_d.skew.chipset = skew3(c_q.skew_byte[`WRFC_CS_HI:`WRFC_CS_LO]); // R7
      c_d.skew.graphics =
         skew2(c_q.skew_byte[`WRFC_AGP_HI:`WRFC_AGP_LO]); // R8
      if (ratio_source_override) begin
         c_d.ratio = ratio_select_sw; // R12
      end else begin
         c_d.ratio = c_q.strap_lat; // R12
      end

      // Power-on reset; a watchdog system reset does not come here.
      if (!rst_n) begin
         // Handshake toward the link side.
         c_d.req_sync = 3'h0;
         c_d.ack_tgl = 1'b0;
         c_d.rdata_hold = `WRFC_RST_BYTE;
         // Strap latch and stored control bytes.
         c_d.strap_age = 2'h0;
         c_d.strap_lat = 5'h00;
         c_d.flag = `WRFC_RST_BIT;
         c_d.run = `WRFC_RST_BIT;
         c_d.rst_en = `WRFC_RST_BIT;
         c_d.skew_byte = `WRFC_RST_BYTE; // R15
         c_d.n_byte = `WRFC_RST_BYTE; // R15
         c_d.m_byte = `WRFC_RST_BYTE; // R15
         // Watchdog sequencing and the reset pulse.
         c_d.wd = wrfc_pkg::WD_STOP;
         c_d.pre_cnt = 26'h0;
         c_d.units = 6'h00;
         c_d.rst_cnt = 8'h00;
         c_d.sys_rst = 1'b0;
         c_d.rec_load = 1'b0;
         c_d.lock = 1'b0;
         // Results toward the synthesiser.
         c_d.rec = '0;
         c_d.skew = '0;
         c_d.ratio = 5'h00;
      end
   end

   // Registers the core domain state.
   always_ff @(posedge clk) begin
      c_q <= c_d;
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Every output is a flip-flop of one of the two state records.
   assign smb_busy = l_q.pending;
   assign smb_rdata = l_q.rdata;
   assign smb_rdata_vld = l_q.rvld;

   // Watchdog results stay on the reference clock.
   assign sys_reset = c_q.sys_rst;
   assign recovery_load = c_q.rec_load;
   assign recovery_lock = c_q.lock; // R5
   assign recovery = c_q.rec;
   assign skew = c_q.skew;
   assign ratio_select = c_q.ratio;

endmodule

// ==== wrfc_consts.svh ====
`ifndef WRFC_CONSTS_SVH
`define WRFC_CONSTS_SVH

// ----------------------------------------------------------------
// Control byte offsets
// ----------------------------------------------------------------
`define WRFC_OFS_WDOG 8'h09
`define WRFC_OFS_SKEW 8'h0a
`define WRFC_OFS_RECN 8'h0b
`define WRFC_OFS_RECM 8'h0c

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define WRFC_BIT_RSTEN 4
`define WRFC_BIT_FLAG 2
`define WRFC_BIT_RUN 1
`define WRFC_BIT_RSEL 7
`define WRFC_CS_HI 7
`define WRFC_CS_LO 5
`define WRFC_CPU_HI 4
`define WRFC_CPU_LO 2
`define WRFC_AGP_HI 1
`define WRFC_AGP_LO 0

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define WRFC_RST_BYTE 8'h00
`define WRFC_RST_BIT 1'b0

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define WRFC_CLK_KHZ 25000
`define WRFC_UNIT_SHORT_MS 150
`define WRFC_UNIT_LONG_MS 2500
`define WRFC_UNIT_SHORT_CYC (`WRFC_UNIT_SHORT_MS * `WRFC_CLK_KHZ)
`define WRFC_UNIT_LONG_CYC (`WRFC_UNIT_LONG_MS * `WRFC_CLK_KHZ)
`define WRFC_PRE_W 26
`define WRFC_RST_PULSE_CYC 8'h10
`define WRFC_STRAP_AGE 2'h3

`endif

// ==== wrfc_pkg.sv ====
package wrfc_pkg;

   // Watchdog sequencing states.
   typedef enum logic [1:0] {
      WD_STOP,
      WD_ARMED,
      WD_COUNT,
      WD_LOCKED
   } wrfc_wd_t;

   // Output skews in signed steps of 150 ps.
   typedef struct packed {
      logic signed [3:0] cpu;
      logic signed [3:0] chipset;
      logic signed [3:0] graphics;
   } wrfc_skew_t;

   // Recovery frequency handed to the synthesiser.
   typedef struct packed {
      logic use_dividers;
      logic [7:0] n;
      logic [6:0] m;
      logic [4:0] strap;
   } wrfc_recov_t;

   // State of the reference clock domain.
   typedef struct packed {
      logic [2:0] req_sync;
      logic ack_tgl;
      logic [7:0] rdata_hold;
      logic [4:0] strap_s1;
      logic [4:0] strap_s2;
      logic [1:0] strap_age;
      logic [4:0] strap_lat;
      logic flag;
      logic run;
      logic rst_en;
      logic [7:0] skew_byte;
      logic [7:0] n_byte;
      logic [7:0] m_byte;
      wrfc_wd_t wd;
      logic [25:0] pre_cnt;
      logic [5:0] units;
      logic [7:0] rst_cnt;
      logic sys_rst;
      logic rec_load;
      logic lock;
      wrfc_recov_t rec;
      wrfc_skew_t skew;
      logic [4:0] ratio;
   } wrfc_core_t;

   // State of the link clock domain.
   typedef struct packed {
      logic [1:0] rst_sync;
      logic req_tgl;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
      logic [1:0] ack_sync;
      logic pending;
      logic [7:0] rdata;
      logic rvld;
   } wrfc_link_t;

endpackage

// ==== wrfc_top_asserts.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Watchdog and recovery checks
// ----------------------------------------
module wrfc_top_asserts (
   // Clock and reset.
   input logic clk,
   input logic rst_n,
   // Ratio controls.
   input logic ratio_source_override,
   input logic [4:0] ratio_select_sw,
   // Watched results.
   input logic sys_reset,
   input logic recovery_load,
   input logic recovery_lock,
   input wrfc_pkg::wrfc_recov_t recovery,
   input wrfc_pkg::wrfc_skew_t skew,
   input logic [4:0] ratio_select
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   logic [7:0] hi_q;

   // Counts the cycles of the current system reset pulse.
   always_ff @(posedge clk) begin
      hi_q <= (rst_n && sys_reset) ? hi_q + 8'h01 : 8'h00;
   end

   // Time-out events and what follows them, then the ratio source and the skew ranges.
   chk_load_pulse: assert property (recovery_load |=> !recovery_load)
      else $error("recovery load longer than one cycle");
   chk_load_locks: assert property (
      recovery_load |-> ##[0:1] recovery_lock)
      else $error("no lock after recovery load");
   chk_lock_cause: assert property (
      $rose(recovery_lock) |-> recovery_load || $past(recovery_load))
      else $error("lock without time-out");
   chk_reset_len: assert property ($fell(sys_reset) |-> hi_q == 8'h10)
      else $error("system reset pulse length wrong");
   chk_reset_cause: assert property (
      $rose(sys_reset) |-> recovery_load || $past(recovery_load))
      else $error("system reset without time-out");
   chk_recov_hold: assert property (
      $changed(recovery) |-> recovery_load || $past(recovery_load))
      else $error("recovery value moved outside time-out");
   chk_ratio_soft: assert property (
      $past(rst_n) && ratio_source_override && $stable(ratio_select_sw)
      |=> ratio_select == $past(ratio_select_sw))
      else $error("ratio not taken from software select");
   chk_skew_span: assert property (
      skew.cpu >= -3 && skew.cpu <= 4 && skew.chipset >= -3 &&
      skew.chipset <= 4 && skew.graphics >= -1 && skew.graphics <= 2)
      else $error("skew step outside its table");

   // Main scenarios.
   cover property (recovery_load);
   cover property ($rose(sys_reset));
   cover property ($fell(recovery_lock));
endmodule

// ==== wrfc_host.sv ====
`timescale 1ns/100ps
// ----------------------------------------
// Control byte host
// ----------------------------------------
module wrfc_host (
   // Link clock.
   input logic smb_clk,
   // Requests toward the block.
   output logic smb_wr_stb,
   output logic smb_rd_stb,
   output logic [7:0] smb_addr,
   output logic [7:0] smb_wdata,
   // Answers from the block.
   input logic smb_busy,
   input logic [7:0] smb_rdata,
   input logic smb_rdata_vld
);
   // Request lines start idle.
   initial begin
      smb_wr_stb = 1'b0;
      smb_rd_stb = 1'b0;
      smb_addr = 8'h00;
      smb_wdata = 8'h00;
   end

   // Issues one byte request and waits a bounded time for its answer.
   task automatic xfer(input logic w, input logic [7:0] a,
         input logic [7:0] d, output logic [7:0] q);
      q = 8'hxx;
      @(posedge smb_clk);
      smb_wr_stb <= w;
      smb_rd_stb <= !w;
      smb_addr <= a;
      smb_wdata <= d;
      @(posedge smb_clk);
      smb_wr_stb <= 1'b0;
      smb_rd_stb <= 1'b0;
      smb_addr <= ~a; // Released lines carry no stale value.
      smb_wdata <= ~d;
      // Answers are looked at mid-cycle, where they have settled.
      repeat (64) begin
         @(negedge smb_clk);
         if (smb_rdata_vld === 1'b1) q = smb_rdata;
         if (smb_busy === 1'b0) break;
      end
   endtask
endmodule

// ==== wrfc_top_tb.sv ====
`timescale 1ns/100ps
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin \
   error_cnt++; $display("unexpected %s exp %h got %h", n, e, g); end end
// ----------------------------------------
// Testbench
// ----------------------------------------
module wrfc_top_tb;
   logic clk, rst_n, smb_clk, smb_wr_stb, smb_rd_stb, smb_busy;
   logic smb_rdata_vld, freq_change, ratio_source_override;
   logic timeout_prescale_select, sys_reset, recovery_load, recovery_lock;
   logic [7:0] smb_addr, smb_wdata, smb_rdata;
   logic [4:0] strap_frequency_select, timeout_count, ratio_select_sw;
   logic [4:0] ratio_select;
   wrfc_pkg::wrfc_recov_t recovery;
   wrfc_pkg::wrfc_skew_t skew;
   int error_cnt, comparisons, cyc, ld_cnt, hi_cnt, n;
   logic [3:0] gt [4] = '{4'h0, 4'hf, 4'h1, 4'h2};
   logic [7:0] ofs [5] = '{8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h20};

   wrfc_top #(.UNIT_SHORT_CYC(10), .UNIT_LONG_CYC(40)) wrfc_top_inst (
      .clk, .rst_n, .smb_clk, .smb_wr_stb, .smb_rd_stb, .smb_addr,
      .smb_wdata, .smb_busy, .smb_rdata, .smb_rdata_vld,
      .strap_frequency_select, .timeout_count, .timeout_prescale_select,
      .freq_change, .ratio_source_override, .ratio_select_sw, .sys_reset,
      .recovery_load, .recovery_lock, .recovery, .skew, .ratio_select);
   wrfc_host wrfc_host_inst (.smb_clk, .smb_wr_stb, .smb_rd_stb,
      .smb_addr, .smb_wdata, .smb_busy, .smb_rdata, .smb_rdata_vld);

   // Clocks of the two domains.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      smb_clk = 1'b0;
      #7 forever #7.5 smb_clk = ~smb_clk;
   end

   // Counts events and cuts a hang short.
   always @(posedge clk) begin
      cyc++;
      ld_cnt += (rst_n && recovery_load === 1'b1);
      hi_cnt += (rst_n && sys_reset === 1'b1);
      if (cyc == 20000) begin
         error_cnt++;
         print_verdict();
      end
   end

   // Byte access and event helpers.
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      logic [7:0] q;
      wrfc_host_inst.xfer(1'b1, a, d, q);
   endtask
   task automatic rc(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] q;
      wrfc_host_inst.xfer(1'b0, a, 8'h00, q);
      `CHK("byte", e, q)
   endtask
   task automatic kick(output int k);
      @(posedge clk);
      freq_change <= 1'b1;
      @(posedge clk);
      freq_change <= 1'b0;
      k = 0;
      while (recovery_load !== 1'b1 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      repeat (2) @(posedge clk);
   endtask
   function automatic logic [3:0] sk3(input int i);
      return (i < 4) ? 4'(-i) : 4'(i - 3);
   endfunction
   task automatic print_verdict;
      if (error_cnt == 0 && comparisons > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      rst_n = 1'b0;
      freq_change = 1'b0;
      ratio_source_override = 1'b0;
      timeout_prescale_select = 1'b0;
      timeout_count = 5'h02;
      ratio_select_sw = 5'h0a;
      strap_frequency_select = 5'h15;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      repeat (4) @(posedge clk);
      foreach (ofs[i]) rc(ofs[i], 8'h00);
      `CHK("ratio", 5'h15, ratio_select)
      @(posedge clk);
      ratio_source_override <= 1'b1;
      repeat (3) @(posedge clk);
      `CHK("ratio", 5'h0a, ratio_select)
      for (int i = 0; i < 8; i++) begin
         wr(8'h0a, {i[2:0], i[2:0], i[1:0]});
         repeat (3) @(posedge clk);
         `CHK("cpu skew", sk3(i), skew.cpu)
         `CHK("cs skew", sk3(i), skew.chipset)
         `CHK("graphics_port_clock_skew", gt[i%4], skew.graphics)
      end
      wr(8'h0b, 8'ha5);
      wr(8'h0c, 8'hbc);
      wr(8'h09, 8'h12);
      repeat (200) @(posedge clk);
      `CHK("early load", 0, ld_cnt)
      kick(n);
      `CHK("short wait", 1'b1, n >= 30 && n <= 34)
      `CHK("recovery", {1'b1, 8'ha5, 7'h3c}, recovery[20:5])
      `CHK("lock", 1'b1, recovery_lock)
      repeat (20) @(posedge clk);
      `CHK("reset len", 16, hi_cnt)
      rc(8'h09, 8'h16);
      rc(8'h0a, 8'hff);
      wr(8'h0b, 8'h11);
      rc(8'h0b, 8'ha5);
      wr(8'h09, 8'h12);
      rc(8'h09, 8'h16);
      wr(8'h09, 8'h16);
      rc(8'h09, 8'h12);
      `CHK("lock", 1'b1, recovery_lock)
      wr(8'h09, 8'h00);
      repeat (3) @(posedge clk);
      `CHK("lock", 1'b0, recovery_lock)
      wr(8'h0b, 8'h11);
      rc(8'h0b, 8'h11);
      wr(8'h0c, 8'h00);
      @(posedge clk);
      timeout_prescale_select <= 1'b1;
      timeout_count <= 5'h00;
      kick(n);
      `CHK("stopped", 2000, n)
      wr(8'h09, 8'h02);
      kick(n);
      `CHK("long wait", 1'b1, n >= 40 && n <= 44)
      `CHK("strap source", 6'h15, {recovery[20], recovery[4:0]})
      `CHK("reset len", 16, hi_cnt)
      rc(8'h09, 8'h06);
      print_verdict();
   end
endmodule

bind wrfc_top wrfc_top_asserts wrfc_top_asserts_inst (.clk, .rst_n,
   .ratio_source_override, .ratio_select_sw, .sys_reset, .recovery_load,
   .recovery_lock, .recovery, .skew, .ratio_select);
